// >>> pkg/csc_consts.vh
// constants for the clock synthesizer configuration bytes
`ifndef CSC_CONSTS_VH
`define CSC_CONSTS_VH

// ----------------------------------------------------------------
// register offsets
// ----------------------------------------------------------------
`define CSC_OFS_STRAP      8'h05
`define CSC_OFS_CPU_STOP   8'h06
`define CSC_OFS_PCI_EN     8'h07
`define CSC_OFS_MAKER      8'h08
`define CSC_OFS_MISC       8'h09

// ----------------------------------------------------------------
// reset values, writable masks and the strap read mask
// ----------------------------------------------------------------
`define CSC_RST_CPU_STOP   8'h0b
`define CSC_MSK_CPU_STOP   8'h3f
`define CSC_RST_PCI_EN     8'hff
`define CSC_MSK_PCI_EN     8'hff
`define CSC_RST_MISC       8'hb0
`define CSC_MSK_MISC       8'hbf
`define CSC_MSK_STRAP      8'h0f

// ----------------------------------------------------------------
// field positions
// ----------------------------------------------------------------
`define CSC_B6_STOP_FPCI0  5
`define CSC_B6_STOP_FPCI1  4
`define CSC_B6_STOP_CPU0   3
`define CSC_B6_STOP_CPU1   2
`define CSC_B6_EN_CPU0     1
`define CSC_B6_EN_CPU1     0
`define CSC_B7_EN_FPCI1    7
`define CSC_B7_EN_FPCI0    6
`define CSC_B9_PDN         7
`define CSC_B9_EN_USB      5
`define CSC_B9_EN_SIO      4
`define CSC_B9_SIO_48      3
`define CSC_B9_SS_TYPE     2

// ----------------------------------------------------------------
// identification, arbitrary values
// ----------------------------------------------------------------
`define CSC_MAKER_CODE     4'h5
`define CSC_REVISION_CODE  4'h1
`define CSC_DEV_ADDR       7'h2a

// ----------------------------------------------------------------
// serial link and strap timing
// ----------------------------------------------------------------
`define CSC_BITS_PER_BYTE  4'h8
`define CSC_STRAP_WAIT     2'h3

`endif

// >>> core/csc_sync.v
// two flip-flop synchroniser for pin inputs
`timescale 1ns/1ps
module csc_sync #(
  parameter W = 8
) (
  input  wire         core_clk,
  input  wire         arst_n,
  input  wire [W-1:0] pin_in,
  output reg  [W-1:0] pin_sync
);
  reg [W-1:0] stage_a;

  always @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      stage_a  <= {W{1'b0}};
      pin_sync <= {W{1'b0}};
    end else begin
      stage_a  <= pin_in;
      pin_sync <= stage_a;
    end
  end
endmodule // csc_sync

// >>> core/csc_out_ctrl.v
// output run, three-state and spread decode from configuration bytes
`timescale 1ns/1ps
`include "csc_consts.vh"
module csc_out_ctrl (
  input  wire       core_clk,
  input  wire       arst_n,
  input  wire [7:0] cpu_stop_and_enable,
  input  wire [7:0] pci_output_enables,
  input  wire [7:0] misc_clock_and_spread,
  input  wire       pci_halt,
  input  wire       cpu_halt,
  output reg  [1:0] free_pci_clk_run,
  output reg  [5:0] pci_clk_run,
  output reg        cpu_diff_pair_0_run,
  output reg        cpu_diff_pair_0_hiz,
  output reg        cpu_single_out_1_run,
  output reg        cpu_single_out_1_hiz,
  output reg        usb_clock_out_en,
  output reg        sio_clock_out_en,
  output reg        sio_clock_sel_48,
  output reg        spread_type_bit,
  output reg  [2:0] spread_profile,
  output reg  [7:0] spread_up_pct,
  output reg  [7:0] spread_down_pct
);
  // ----------------------------------------------------------------
  // spread profile decode, hundredths of a percent
  // ----------------------------------------------------------------
  function [15:0] spread_dev;
    input [2:0] prof;
    begin
      case (prof)
        3'h0:    spread_dev = {8'h00, 8'h32};
        3'h1:    spread_dev = {8'h0c, 8'h3e};
        3'h2:    spread_dev = {8'h19, 8'h4b};
        3'h3:    spread_dev = {8'h32, 8'h64};
        3'h4:    spread_dev = {8'h19, 8'h19};
        3'h5:    spread_dev = {8'h25, 8'h25};
        3'h6:    spread_dev = {8'h32, 8'h96};
        default: spread_dev = {8'h4b, 8'h4b};
      endcase
    end
  endfunction

  wire stop_f0 = pci_halt & cpu_stop_and_enable[`CSC_B6_STOP_FPCI0];
  wire stop_f1 = pci_halt & cpu_stop_and_enable[`CSC_B6_STOP_FPCI1];
  wire stop_c0 = cpu_halt & cpu_stop_and_enable[`CSC_B6_STOP_CPU0];
  wire stop_c1 = cpu_halt & cpu_stop_and_enable[`CSC_B6_STOP_CPU1];
  wire [2:0] prof = misc_clock_and_spread[2:0];
  wire [15:0] dev = spread_dev(prof);

  always @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      free_pci_clk_run     <= 2'h3;
      pci_clk_run          <= 6'h3f;
      cpu_diff_pair_0_run  <= 1'b1;
      cpu_diff_pair_0_hiz  <= 1'b0;
      cpu_single_out_1_run <= 1'b1;
      cpu_single_out_1_hiz <= 1'b0;
      usb_clock_out_en     <= 1'b1;
      sio_clock_out_en     <= 1'b1;
      sio_clock_sel_48     <= 1'b0;
      spread_type_bit      <= 1'b0;
      spread_profile       <= 3'h0;
      spread_up_pct        <= 8'h00;
      spread_down_pct      <= 8'h32;
    end else begin
      free_pci_clk_run[0]  <=
        pci_output_enables[`CSC_B7_EN_FPCI0] & ~stop_f0;
      free_pci_clk_run[1]  <=
        pci_output_enables[`CSC_B7_EN_FPCI1] & ~stop_f1;
      pci_clk_run          <= pci_output_enables[5:0];
      cpu_diff_pair_0_run  <=
        cpu_stop_and_enable[`CSC_B6_EN_CPU0] & ~stop_c0;
      cpu_diff_pair_0_hiz  <= stop_c0;
      cpu_single_out_1_run <=
        cpu_stop_and_enable[`CSC_B6_EN_CPU1] & ~stop_c1;
      cpu_single_out_1_hiz <= stop_c1;
      usb_clock_out_en     <= misc_clock_and_spread[`CSC_B9_EN_USB];
      sio_clock_out_en     <= misc_clock_and_spread[`CSC_B9_EN_SIO];
      sio_clock_sel_48     <= misc_clock_and_spread[`CSC_B9_SIO_48];
      spread_type_bit      <= misc_clock_and_spread[`CSC_B9_SS_TYPE];
      spread_profile       <= prof;
      spread_up_pct        <= dev[15:8];
      spread_down_pct      <= dev[7:0];
    end
  end
endmodule // csc_out_ctrl

// >>> core/csc_config_bank.v
// configuration bytes 5 to 9 with a two-wire management slave
`timescale 1ns/1ps
`include "csc_consts.vh"
module csc_config_bank (
  input  wire       core_clk,
  input  wire       arst_n,
  input  wire       smb_clk,
  input  wire       smb_data_in,
  output wire       smb_data_out,
  output reg        smb_data_oe,
  input  wire [3:0] freq_select_straps,
  input  wire       pci_halt_n_in,
  input  wire       cpu_halt_n_in,
  output wire [1:0] free_pci_clk_run,
  output wire [5:0] pci_clk_run,
  output wire       cpu_diff_pair_0_run,
  output wire       cpu_diff_pair_0_hiz,
  output wire       cpu_single_out_1_run,
  output wire       cpu_single_out_1_hiz,
  output wire       usb_clock_out_en,
  output wire       sio_clock_out_en,
  output wire       sio_clock_sel_48,
  output wire       spread_type_bit,
  output wire [2:0] spread_profile,
  output wire [7:0] spread_up_pct,
  output wire [7:0] spread_down_pct,
  output wire       powerdown_enable_n,
  output wire [3:0] strap_value
);
  // ----------------------------------------------------------------
  // slave states
  // ----------------------------------------------------------------
  localparam [3:0] ST_IDLE  = 4'h0;
  localparam [3:0] ST_ADDR  = 4'h1;
  localparam [3:0] ST_AACK  = 4'h2;
  localparam [3:0] ST_CMD   = 4'h3;
  localparam [3:0] ST_CACK  = 4'h4;
  localparam [3:0] ST_WDAT  = 4'h5;
  localparam [3:0] ST_WACK  = 4'h6;
  localparam [3:0] ST_RDAT  = 4'h7;
  localparam [3:0] ST_RACK  = 4'h8;

  reg  [3:0] state;
  reg  [3:0] bit_cnt;
  reg  [7:0] shift;
  reg  [7:0] index;
  reg        rd_mode;
  reg        host_ack;
  reg        scl_q;
  reg        sda_q;
  reg  [7:0] strap_readback;
  reg  [7:0] cpu_stop_and_enable;
  reg  [7:0] pci_output_enables;
  reg  [7:0] misc_clock_and_spread;
  reg  [1:0] strap_wait;
  reg        strap_done;
  reg        wr_pulse;
  reg  [7:0] wr_data;
  reg  [7:0] wr_index;
  wire [7:0] maker_and_revision;
  wire [7:0] pins_sync;

  // ----------------------------------------------------------------
  // pin synchronisers
  // ----------------------------------------------------------------
  // bus and halt pins enter inverted so cleared stages read as idle
  csc_sync #(.W(8)) u_sync (
    .core_clk (core_clk),
    .arst_n   (arst_n),
    .pin_in   ({~smb_clk,
                ~smb_data_in,
                ~pci_halt_n_in,
                ~cpu_halt_n_in,
                freq_select_straps}),
    .pin_sync (pins_sync)
  );

  // ----------------------------------------------------------------
  // bus edge detection
  // ----------------------------------------------------------------
  wire scl_s    = ~pins_sync[7];
  wire sda_s    = ~pins_sync[6];
  wire pci_halt = pins_sync[5];
  wire cpu_halt = pins_sync[4];
  wire scl_rise = scl_s & ~scl_q;
  wire scl_fall = ~scl_s & scl_q;
  wire start_c  = scl_s & scl_q & sda_q & ~sda_s;
  wire stop_c   = scl_s & scl_q & ~sda_q & sda_s;
  wire byte_end = (bit_cnt == `CSC_BITS_PER_BYTE);
  wire addr_hit = (shift[7:1] == `CSC_DEV_ADDR);
  wire [7:0] next_index = index + 8'h01;

  // ----------------------------------------------------------------
  // open-drain data pin and identity
  // ----------------------------------------------------------------
  assign smb_data_out = 1'b0;
  assign maker_and_revision = {`CSC_MAKER_CODE, `CSC_REVISION_CODE};

  // ----------------------------------------------------------------
  // register read decode
  // ----------------------------------------------------------------
  function [7:0] read_reg;
    input [7:0] idx;
    begin
      case (idx)
        `CSC_OFS_STRAP:    read_reg = strap_readback & `CSC_MSK_STRAP;
        `CSC_OFS_CPU_STOP: read_reg = cpu_stop_and_enable;
        `CSC_OFS_PCI_EN:   read_reg = pci_output_enables;
        `CSC_OFS_MAKER:    read_reg = maker_and_revision;
        `CSC_OFS_MISC:     read_reg = misc_clock_and_spread;
        default:           read_reg = 8'h00;
      endcase
    end
  endfunction

  function read_pull;
    input [7:0] idx;
    reg   [7:0] val;
    begin
      val       = read_reg(idx);
      read_pull = ~val[7];
    end
  endfunction

  // ----------------------------------------------------------------
  // strap capture after reset release
  // ----------------------------------------------------------------
  always @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      strap_wait     <= 2'h0;
      strap_done     <= 1'b0;
      strap_readback <= 8'h00;
    end else if (!strap_done) begin
      if (strap_wait == `CSC_STRAP_WAIT) begin
        strap_done     <= 1'b1;
        strap_readback <= {4'h0, pins_sync[3:0]};
      end else begin
        strap_wait <= strap_wait + 2'h1;
      end
    end
  end

  // ----------------------------------------------------------------
  // register writes
  // ----------------------------------------------------------------
  always @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      cpu_stop_and_enable   <= `CSC_RST_CPU_STOP;
      pci_output_enables    <= `CSC_RST_PCI_EN;
      misc_clock_and_spread <= `CSC_RST_MISC;
    end else if (wr_pulse) begin
      case (wr_index)
        `CSC_OFS_CPU_STOP:
          cpu_stop_and_enable <= wr_data & `CSC_MSK_CPU_STOP;
        `CSC_OFS_PCI_EN:
          pci_output_enables <= wr_data & `CSC_MSK_PCI_EN;
        `CSC_OFS_MISC:
          misc_clock_and_spread <= wr_data & `CSC_MSK_MISC;
        default: ;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // two-wire slave
  // ----------------------------------------------------------------
  always @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      state       <= ST_IDLE;
      bit_cnt     <= 4'h0;
      shift       <= 8'h00;
      index       <= 8'h00;
      rd_mode     <= 1'b0;
      host_ack    <= 1'b0;
      scl_q       <= 1'b1;
      sda_q       <= 1'b1;
      smb_data_oe <= 1'b0;
      wr_pulse    <= 1'b0;
      wr_data     <= 8'h00;
      wr_index    <= 8'h00;
    end else begin
      scl_q    <= scl_s;
      sda_q    <= sda_s;
      wr_pulse <= 1'b0;
      if (start_c) begin
        state       <= ST_ADDR;
        bit_cnt     <= 4'h0;
        smb_data_oe <= 1'b0;
      end else if (stop_c) begin
        state       <= ST_IDLE;
        smb_data_oe <= 1'b0;
      end else if (scl_rise) begin
        case (state)
          ST_ADDR, ST_CMD, ST_WDAT: begin
            shift   <= {shift[6:0], sda_s};
            bit_cnt <= bit_cnt + 4'h1;
          end
          ST_RDAT: bit_cnt <= bit_cnt + 4'h1;
          ST_RACK: host_ack <= ~sda_s;
          default: ;
        endcase
      end else if (scl_fall) begin
        case (state)
          ST_ADDR: begin
            if (byte_end) begin
              if (addr_hit) begin
                rd_mode     <= shift[0];
                smb_data_oe <= 1'b1;
                state       <= ST_AACK;
              end else begin
                state <= ST_IDLE;
              end
            end
          end
          ST_AACK: begin
            bit_cnt <= 4'h0;
            if (rd_mode) begin
              shift       <= read_reg(index);
              smb_data_oe <= read_pull(index);
              state       <= ST_RDAT;
            end else begin
              smb_data_oe <= 1'b0;
              state       <= ST_CMD;
            end
          end
          ST_CMD: begin
            if (byte_end) begin
              index       <= shift;
              smb_data_oe <= 1'b1;
              state       <= ST_CACK;
            end
          end
          ST_CACK: begin
            bit_cnt     <= 4'h0;
            smb_data_oe <= 1'b0;
            state       <= ST_WDAT;
          end
          ST_WDAT: begin
            if (byte_end) begin
              wr_pulse    <= 1'b1;
              wr_data     <= shift;
              wr_index    <= index;
              smb_data_oe <= 1'b1;
              state       <= ST_WACK;
            end
          end
          ST_WACK: begin
            bit_cnt     <= 4'h0;
            index       <= next_index;
            smb_data_oe <= 1'b0;
            state       <= ST_WDAT;
          end
          ST_RDAT: begin
            if (byte_end) begin
              smb_data_oe <= 1'b0;
              state       <= ST_RACK;
            end else begin
              shift       <= {shift[6:0], 1'b0};
              smb_data_oe <= ~shift[6];
            end
          end
          ST_RACK: begin
            bit_cnt <= 4'h0;
            if (host_ack) begin
              shift       <= read_reg(next_index);
              smb_data_oe <= read_pull(next_index);
              index       <= next_index;
              state       <= ST_RDAT;
            end else begin
              state <= ST_IDLE;
            end
          end
          default: state <= ST_IDLE;
        endcase
      end
    end
  end

  // ----------------------------------------------------------------
  // output control
  // ----------------------------------------------------------------
  assign powerdown_enable_n = misc_clock_and_spread[`CSC_B9_PDN];
  assign strap_value        = strap_readback[3:0];

  csc_out_ctrl u_out (
    .core_clk              (core_clk),
    .arst_n                (arst_n),
    .cpu_stop_and_enable   (cpu_stop_and_enable),
    .pci_output_enables    (pci_output_enables),
    .misc_clock_and_spread (misc_clock_and_spread),
    .pci_halt              (pci_halt),
    .cpu_halt              (cpu_halt),
    .free_pci_clk_run      (free_pci_clk_run),
    .pci_clk_run           (pci_clk_run),
    .cpu_diff_pair_0_run   (cpu_diff_pair_0_run),
    .cpu_diff_pair_0_hiz   (cpu_diff_pair_0_hiz),
    .cpu_single_out_1_run  (cpu_single_out_1_run),
    .cpu_single_out_1_hiz  (cpu_single_out_1_hiz),
    .usb_clock_out_en      (usb_clock_out_en),
    .sio_clock_out_en      (sio_clock_out_en),
    .sio_clock_sel_48      (sio_clock_sel_48),
    .spread_type_bit       (spread_type_bit),
    .spread_profile        (spread_profile),
    .spread_up_pct         (spread_up_pct),
    .spread_down_pct       (spread_down_pct)
  );
endmodule // csc_config_bank

// >>> dv/csc_config_bank_properties.sv
// concurrent checks on the configuration bank ports
`timescale 1ns/1ps
module csc_config_bank_properties (
  input wire       core_clk,
  input wire       arst_n,
  input wire       smb_clk,
  input wire       smb_data_out,
  input wire       smb_data_oe,
  input wire [3:0] freq_select_straps,
  input wire       cpu_halt_n_in,
  input wire       cpu_diff_pair_0_run,
  input wire       cpu_diff_pair_0_hiz,
  input wire       cpu_single_out_1_run,
  input wire       cpu_single_out_1_hiz,
  input wire       spread_type_bit,
  input wire [2:0] spread_profile,
  input wire [7:0] spread_up_pct,
  input wire [7:0] spread_down_pct,
  input wire [3:0] strap_value
);
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!arst_n);
  logic [3:0] up_cnt;
  always @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) up_cnt <= 4'h0;
    else if (up_cnt != 4'hf) up_cnt <= up_cnt + 4'h1;
  end
  function automatic logic [15:0] pct(input logic [2:0] p);
    case (p)
      3'h0: pct = 16'h0032;
      3'h1: pct = 16'h0c3e;
      3'h2: pct = 16'h194b;
      3'h3: pct = 16'h3264;
      3'h4: pct = 16'h1919;
      3'h5: pct = 16'h2525;
      3'h6: pct = 16'h3296;
      default: pct = 16'h4b4b;
    endcase
  endfunction
  sequence s_cpu_free;
    cpu_halt_n_in[*5];
  endsequence
  sequence s_clk_fall;
    ##[0:40] $fell(smb_clk);
  endsequence
  a_strap_capture: assert property (up_cnt == 4'h8 |->
    strap_value == freq_select_straps) else $error("strap not captured");
  a_strap_frozen: assert property (up_cnt == 4'hf |->
    $stable(strap_value)) else $error("strap value moved");
  a_spread_type: assert property (spread_type_bit == spread_profile[2])
    else $error("spread type differs from profile");
  a_spread_table: assert property (
    {spread_up_pct, spread_down_pct} == pct(spread_profile))
    else $error("spread percentages wrong");
  a_cpu_no_hiz: assert property (s_cpu_free |->
    !cpu_diff_pair_0_hiz && !cpu_single_out_1_hiz)
    else $error("three-state without cpu halt");
  a_hiz_not_run: assert property (
    !(cpu_diff_pair_0_hiz && cpu_diff_pair_0_run) &&
    !(cpu_single_out_1_hiz && cpu_single_out_1_run))
    else $error("cpu output both running and three-state");
  a_oe_clock_low: assert property ($changed(smb_data_oe) |->
    $past(!smb_clk)) else $error("data pull changed with bus clock high");
  a_ack_holds: assert property ($rose(smb_data_oe) |=>
    smb_data_oe throughout s_clk_fall) else $error("data pull dropped early");
  a_drain_low: assert property (smb_data_out == 1'b0)
    else $error("open drain output not low");
endmodule // csc_config_bank_properties
bind csc_config_bank csc_config_bank_properties csc_config_bank_properties_i (
  .core_clk(core_clk), .arst_n(arst_n), .smb_clk(smb_clk),
  .smb_data_out(smb_data_out), .smb_data_oe(smb_data_oe),
  .freq_select_straps(freq_select_straps), .cpu_halt_n_in(cpu_halt_n_in),
  .cpu_diff_pair_0_run(cpu_diff_pair_0_run),
  .cpu_diff_pair_0_hiz(cpu_diff_pair_0_hiz),
  .cpu_single_out_1_run(cpu_single_out_1_run),
  .cpu_single_out_1_hiz(cpu_single_out_1_hiz),
  .spread_type_bit(spread_type_bit), .spread_profile(spread_profile),
  .spread_up_pct(spread_up_pct), .spread_down_pct(spread_down_pct),
  .strap_value(strap_value)
);

// >>> dv/csc_host_model.sv
// management bus host model driving bus clock and data
`timescale 1ns/1ps
`include "csc_consts.vh"
module csc_host_model (
  output logic smb_clk,
  output logic sda_drv,
  input  wire  sda_wire
);
  // clock stands high and data is released between frames
  initial begin
    smb_clk = 1'b1;
    sda_drv = 1'b1;
  end
  // pins move by non-blocking update, so a change on a core clock edge
  // is never seen by the synchroniser in that same step
  task automatic put(input logic b);
    #50 sda_drv <= b;
    #50 smb_clk <= 1'b1;
    #100 smb_clk <= 1'b0;
  endtask
  task automatic get(output logic b);
    #50 sda_drv <= 1'b1;
    #50 smb_clk <= 1'b1;
    b = sda_wire;
    #100 smb_clk <= 1'b0;
  endtask
  task automatic start;
    #50 sda_drv <= 1'b1;
    #50 smb_clk <= 1'b1;
    #100 sda_drv <= 1'b0;
    #100 smb_clk <= 1'b0;
  endtask
  task automatic stop;
    #50 sda_drv <= 1'b0;
    #50 smb_clk <= 1'b1;
    #100 sda_drv <= 1'b1;
    #100;
  endtask
  task automatic tx(input logic [7:0] d, output logic ack);
    for (int i = 7; i >= 0; i--) put(d[i]);
    get(ack);
    ack = ~ack;
  endtask
  task automatic probe(input logic [7:0] a, output logic ack);
    start;
    tx(a, ack);
    stop;
  endtask
  task automatic wr(input logic [7:0] idx, input logic [15:0] d,
                    input int n, output logic ok);
    logic a0, a1, a2, a3;
    start;
    tx({`CSC_DEV_ADDR, 1'b0}, a0);
    tx(idx, a1);
    tx(d[15:8], a2);
    a3 = 1'b1;
    if (n == 2) tx(d[7:0], a3);
    stop;
    ok = a0 & a1 & a2 & a3;
  endtask
  task automatic rd(input logic [7:0] idx, input int n,
                    output logic [15:0] d, output logic ok);
    logic a0, a1, a2;
    start;
    tx({`CSC_DEV_ADDR, 1'b0}, a0);
    tx(idx, a1);
    start;
    tx({`CSC_DEV_ADDR, 1'b1}, a2);
    d = 16'h0000;
    for (int i = 15; i >= 8; i--) get(d[i]);
    if (n == 2) begin
      put(1'b0);
      for (int i = 7; i >= 0; i--) get(d[i]);
    end
    put(1'b1);
    stop;
    ok = a0 & a1 & a2;
  endtask
endmodule // csc_host_model

// >>> dv/testbench.sv
// self-checking bench for the configuration bank
`timescale 1ns/1ps
`include "csc_consts.vh"
module testbench;
  logic       core_clk, arst_n, pci_halt_n_in, cpu_halt_n_in;
  logic [3:0] freq_select_straps;
  wire        smb_clk, sda_drv, sda_wire, smb_data_out, smb_data_oe;
  wire [1:0]  free_pci_clk_run;
  wire [5:0]  pci_clk_run;
  wire        cd0_run, cd0_hiz, cs1_run, cs1_hiz, usb_en, sio_en, sio_48;
  wire        ss_type, pdn_n;
  wire [2:0]  ss_prof;
  wire [3:0]  strap_value;
  wire [7:0]  en_view = {free_pci_clk_run, pci_clk_run};
  wire [3:0]  cpu_view = {cd0_run, cd0_hiz, cs1_run, cs1_hiz};
  wire [7:0]  misc_view = {pdn_n, usb_en, sio_en, sio_48, ss_type, ss_prof};
  int         n_fail, n_tests;
  assign sda_wire = (smb_data_oe ? smb_data_out : 1'b1) & sda_drv;
  csc_host_model host_i (.smb_clk(smb_clk), .sda_drv(sda_drv),
    .sda_wire(sda_wire));
  csc_config_bank csc_config_bank_i (.core_clk(core_clk), .arst_n(arst_n),
    .smb_clk(smb_clk), .smb_data_in(sda_wire), .smb_data_out(smb_data_out),
    .smb_data_oe(smb_data_oe), .freq_select_straps(freq_select_straps),
    .pci_halt_n_in(pci_halt_n_in), .cpu_halt_n_in(cpu_halt_n_in),
    .free_pci_clk_run(free_pci_clk_run), .pci_clk_run(pci_clk_run),
    .cpu_diff_pair_0_run(cd0_run), .cpu_diff_pair_0_hiz(cd0_hiz),
    .cpu_single_out_1_run(cs1_run), .cpu_single_out_1_hiz(cs1_hiz),
    .usb_clock_out_en(usb_en), .sio_clock_out_en(sio_en),
    .sio_clock_sel_48(sio_48), .spread_type_bit(ss_type),
    .spread_profile(ss_prof), .spread_up_pct(), .spread_down_pct(),
    .powerdown_enable_n(pdn_n), .strap_value(strap_value));
  always #12.5 core_clk = ~core_clk;
  task automatic close_out;
    if (n_fail == 0 && n_tests > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    n_tests++;
    if (seen !== exp) begin
      n_fail++;
      $display("MISMATCH %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wchk(input logic [7:0] idx, input logic [15:0] d, int n);
    logic ok;
    host_i.wr(idx, d, n, ok);
    chk({7'h00, ok}, 8'h01);
  endtask
  task automatic rchk(input logic [7:0] idx, input logic [7:0] exp);
    logic ok;
    logic [15:0] d;
    host_i.rd(idx, 1, d, ok);
    chk({7'h00, ok}, 8'h01);
    chk(d[15:8], exp);
  endtask
  task automatic t_reset_values;
    rchk(`CSC_OFS_STRAP, 8'h0a);
    rchk(`CSC_OFS_CPU_STOP, 8'h0b);
    rchk(`CSC_OFS_PCI_EN, 8'hff);
    rchk(`CSC_OFS_MAKER, {`CSC_MAKER_CODE, `CSC_REVISION_CODE});
    rchk(`CSC_OFS_MISC, 8'hb0);
    chk(en_view, 8'hff);
    chk({4'h0, cpu_view}, 8'h0a);
    chk(misc_view, 8'he0);
  endtask
  task automatic t_read_only;
    logic ack;
    logic ok;
    logic [15:0] d;
    @(posedge core_clk);
    freq_select_straps <= 4'h5;
    wchk(`CSC_OFS_STRAP, 16'hff00, 1);
    wchk(`CSC_OFS_MAKER, 16'h0000, 1);
    rchk(`CSC_OFS_STRAP, 8'h0a);
    rchk(`CSC_OFS_MAKER, {`CSC_MAKER_CODE, `CSC_REVISION_CODE});
    chk({4'h0, strap_value}, 8'h0a);
    host_i.probe(8'h10, ack);
    chk({7'h00, ack}, 8'h00);
    rchk(8'h0c, 8'h00);
    host_i.rd(`CSC_OFS_PCI_EN, 2, d, ok);
    chk({7'h00, ok}, 8'h01);
    chk(d[15:8], 8'hff);
    chk(d[7:0], {`CSC_MAKER_CODE, `CSC_REVISION_CODE});
  endtask
  task automatic t_enables;
    wchk(`CSC_OFS_CPU_STOP, 16'hfc0f, 2);
    rchk(`CSC_OFS_CPU_STOP, 8'h3c);
    rchk(`CSC_OFS_PCI_EN, 8'h0f);
    chk(en_view, 8'h0f);
    chk({4'h0, cpu_view}, 8'h00);
    wchk(`CSC_OFS_CPU_STOP, 16'h0bff, 2);
    chk(en_view, 8'hff);
  endtask
  task automatic halt_case(input logic [7:0] cfg, input logic [5:0] exp);
    wchk(`CSC_OFS_CPU_STOP, {cfg, 8'h00}, 1);
    repeat (4) @(posedge core_clk);
    chk({2'b00, free_pci_clk_run, cpu_view}, {2'b00, exp});
  endtask
  task automatic t_halts;
    @(posedge core_clk);
    pci_halt_n_in <= 1'b0;
    cpu_halt_n_in <= 1'b0;
    halt_case(8'h2b, 6'b10_0110);
    halt_case(8'h17, 6'b01_1001);
    halt_case(8'h03, 6'b11_1010);
    chk(en_view, 8'hff);
    @(posedge core_clk);
    pci_halt_n_in <= 1'b1;
    cpu_halt_n_in <= 1'b1;
    halt_case(8'h3f, 6'b11_1010);
    wchk(`CSC_OFS_CPU_STOP, 16'h0b00, 1);
  endtask
  task automatic t_spread;
    logic [2:0] p;
    logic [7:0] d;
    for (int i = 0; i < 8; i++) begin
      p = i[2:0];
      d = {2'b11, p[1], p[0], p[1], p};
      wchk(`CSC_OFS_MISC, {d, 8'h00}, 1);
      rchk(`CSC_OFS_MISC, {2'b10, d[5:0]});
      chk(misc_view, {1'b1, p[1], p[0], p[1], p[2], p});
    end
    wchk(`CSC_OFS_MISC, 16'hb000, 1);
  endtask
  initial begin
    core_clk = 1'b0;
    arst_n = 1'b0;
    pci_halt_n_in = 1'b1;
    cpu_halt_n_in = 1'b1;
    freq_select_straps = 4'ha;
    n_fail = 0;
    n_tests = 0;
    repeat (16) @(posedge core_clk);
    arst_n <= 1'b1;
    repeat (8) @(posedge core_clk);
    t_reset_values;
    t_read_only;
    t_enables;
    t_halts;
    t_spread;
    close_out;
  end
  initial begin
    #2000000;
    n_fail++;
    close_out;
  end
endmodule // testbench
